// >>> spmc_pkg.sv
// Package: constants and types for the sensor pin mode control block.
// Assumes a single 250 MHz system clock.
package spmc_pkg;
   localparam int unsigned SPMC_CLK_MHZ = 250;
   // Default timing figures in microseconds
   localparam int unsigned SPMC_HIB_ENTRY_US = 10;
   localparam int unsigned SPMC_PULSE_US = 4;
   localparam int unsigned SPMC_HIB_ENTRY_CYC = SPMC_HIB_ENTRY_US * SPMC_CLK_MHZ;
   localparam int unsigned SPMC_PULSE_CYC = SPMC_PULSE_US * SPMC_CLK_MHZ;
   localparam int unsigned SPMC_CNT_W = 24;
   localparam logic [1:0] SPMC_THR_RST = 2'h0;
   localparam logic [1:0] SPMC_IRQ_CFG_RST = 2'h0;
   // Interrupt pin output type
   typedef enum logic [1:0] {
      SPMC_PP = 2'h0,
      SPMC_OD = 2'h1,
      SPMC_OS = 2'h2,
      SPMC_IN = 2'h3
   } spmc_irq_cfg_type;
   // Motion line state machine, one-hot
   typedef enum logic [3:0] {
      SPMC_ST_BOOT = 4'h1,
      SPMC_ST_ARMED = 4'h2,
      SPMC_ST_PULSE = 4'h4,
      SPMC_ST_HIB = 4'h8
   } spmc_state_type;
endpackage

// >>> spmc_irq_pad.sv
// Output-type driver for one interrupt pin.
// Assumes the pin wire resolves drive from oe_n (low = driving).
`timescale 1ns/100ps
`default_nettype none
module spmc_irq_pad
   import spmc_pkg::*;
(
   // Configuration
   input wire spmc_irq_cfg_type cfg,
   input wire logic hiz,
   // Level
   input wire logic level,
   // Pin
   output logic pin_out,
   output logic pin_oe_n
);
   always_comb begin
      pin_out = level;
      pin_oe_n = 1'b0;
      if (hiz || cfg == SPMC_IN) begin
         pin_oe_n = 1'b1;
      end else if (cfg == SPMC_OD) begin
         pin_out = 1'b0;
         pin_oe_n = level;
      end else if (cfg == SPMC_OS) begin
         pin_out = 1'b1;
         pin_oe_n = ~level;
      end
   end
endmodule
`default_nettype wire

// >>> spmc_top.sv
// Pin function and mode steering of the motion sensor.
// Assumes pins are synchronous to clk_sys; pull-ups are external.
// Summary of operation
// - Boot-mode strap is captured once after reset and held.
// - Strap high: second pin is open-drain boot-complete output.
// - Strap low: second pin is interrupt b output or external trigger input.
// - Seventh pin is SPI chip select; wake-up only with strap low.
// - Host releases motion line to enable; long low enters hibernate.
// - On motion the device pulls the motion line low for a fixed width.
// - Host low pulses on the motion line select the motion threshold.
// - Interface strap high selects SPI, low selects I2C.
// - In hibernate the serial pins and second pin are high impedance.
// - Hibernate: wake pin and first pin float or input by mode.
// - Interrupt pins configurable; push-pull after reset and hibernate exit.
// - Three-wire select bit switches SPI to one bidirectional data pin.
// - Strap low gives default mode, strap high motion-detection mode.
`timescale 1ns/100ps
`default_nettype none
module spmc_top
   import spmc_pkg::*;
#(
   parameter int unsigned HIB_ENTRY_CYC = SPMC_HIB_ENTRY_CYC,
   parameter int unsigned PULSE_CYC = SPMC_PULSE_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Straps
   input wire logic boot_mode_strap,
   input wire logic host_if_strap,
   // Core configuration
   input wire logic spi_three_wire,
   input wire spmc_irq_cfg_type irq_a_cfg,
   input wire spmc_irq_cfg_type irq_b_cfg,
   input wire logic irq_cfg_load,
   input wire logic ext_sample_trigger_sel,
   input wire logic hib_req,
   // Core events
   input wire logic irq_a_level,
   input wire logic irq_b_level,
   input wire logic boot_done,
   input wire logic motion_event,
   // Serial pins
   input wire logic spi_cs_n_in,
   input wire logic sdata_in,
   input wire logic sdata_core_out,
   input wire logic sdata_core_oe_n,
   input wire logic miso_core_out,
   input wire logic miso_core_oe_n,
   output logic sdata_out,
   output logic sdata_oe_n,
   output logic miso_out,
   output logic miso_oe_n,
   // Pin 6 and pin 8
   input wire logic pin6_in,
   output logic pin6_out,
   output logic pin6_oe_n,
   input wire logic motion_line_in,
   output logic motion_line_out,
   output logic motion_line_oe_n,
   // Status to core
   output logic motion_mode,
   output logic spi_sel,
   output logic spi_3w_active,
   output logic spi_cs_n,
   output logic wake_up,
   output logic ext_sample_trigger,
   output logic detect_en,
   output logic hibernate,
   output logic [1:0] motion_threshold,
   output logic irq_a_in,
   output logic irq_b_in
);
   typedef struct packed {
      logic strap_done;
      logic boot_mode;
      logic if_mode;
      spmc_state_type st;
      logic [SPMC_CNT_W-1:0] cnt;
      logic [1:0] thr;
      spmc_irq_cfg_type cfg_a;
      spmc_irq_cfg_type cfg_b;
      logic hib_prev;
      logic trig_prev;
      logic trig;
      logic wake_prev;
      logic wake;
   } spmc_regs_type;

   spmc_regs_type cur_r;
   spmc_regs_type cur_nxt;
   logic hib_now;
   logic irq_a_pin_out;
   logic irq_a_pin_oe_n;
   logic [SPMC_CNT_W-1:0] hib_lim;
   logic [SPMC_CNT_W-1:0] pulse_lim;

   assign hib_lim = SPMC_CNT_W'(HIB_ENTRY_CYC);
   assign pulse_lim = SPMC_CNT_W'(PULSE_CYC);
   assign hib_now = (cur_r.st == SPMC_ST_HIB) || (!cur_r.boot_mode && hib_req);

   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.trig = 1'b0;
      cur_nxt.wake = 1'b0;
      cur_nxt.hib_prev = hib_now;
      cur_nxt.trig_prev = pin6_in;
      cur_nxt.wake_prev = spi_cs_n_in;
      if (!cur_r.strap_done) begin
         cur_nxt.strap_done = 1'b1;
         cur_nxt.boot_mode = boot_mode_strap;
         cur_nxt.if_mode = host_if_strap;
      end
      // Push-pull after hibernate exit, else software load
      if (cur_r.hib_prev && !hib_now) begin
         cur_nxt.cfg_a = SPMC_PP;
         cur_nxt.cfg_b = SPMC_PP;
      end else if (irq_cfg_load) begin
         cur_nxt.cfg_a = irq_a_cfg;
         cur_nxt.cfg_b = irq_b_cfg;
      end
      // External trigger rising edge, default mode only
      // Edge history is only valid once the strap has been taken
      if (cur_r.strap_done && !cur_r.boot_mode && ext_sample_trigger_sel && pin6_in
          && !cur_r.trig_prev) begin
         cur_nxt.trig = 1'b1;
      end
      // Wake-up on falling edge of pin 7 in default-mode hibernate
      if (!cur_r.boot_mode && hib_now && cur_r.wake_prev && !spi_cs_n_in) begin
         cur_nxt.wake = 1'b1;
      end
      case (cur_r.st)
         SPMC_ST_BOOT: begin
            cur_nxt.cnt = '0;
            if (cur_r.strap_done && cur_r.boot_mode && boot_done) begin
               cur_nxt.st = SPMC_ST_ARMED;
            end
         end
         SPMC_ST_ARMED: begin
            if (!motion_line_in) begin
               cur_nxt.cnt = cur_r.cnt + 1'b1;
               if (cur_r.cnt + 1'b1 >= hib_lim) begin
                  cur_nxt.st = SPMC_ST_HIB;
                  cur_nxt.cnt = '0;
               end
            end else begin
               if (cur_r.cnt != '0) begin
                  cur_nxt.thr = cur_r.thr + 1'b1;
               end
               cur_nxt.cnt = '0;
               if (motion_event) begin
                  cur_nxt.st = SPMC_ST_PULSE;
               end
            end
         end
         SPMC_ST_PULSE: begin
            cur_nxt.cnt = cur_r.cnt + 1'b1;
            if (cur_r.cnt + 1'b1 >= pulse_lim) begin
               cur_nxt.st = SPMC_ST_ARMED;
               cur_nxt.cnt = '0;
            end
         end
         SPMC_ST_HIB: begin
            cur_nxt.cnt = '0;
            if (motion_line_in) begin
               cur_nxt.st = SPMC_ST_ARMED;
            end
         end
         default: begin
            cur_nxt.st = SPMC_ST_BOOT;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur_r <= '{strap_done: 1'b0, boot_mode: 1'b0, if_mode: 1'b0,
                    st: SPMC_ST_BOOT, cnt: '0, thr: SPMC_THR_RST,
                    cfg_a: SPMC_PP, cfg_b: SPMC_PP, hib_prev: 1'b0,
                    trig_prev: 1'b0, trig: 1'b0, wake_prev: 1'b1,
                    wake: 1'b0};
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // Mode and interface status
   assign motion_mode = cur_r.boot_mode;
   assign spi_sel = cur_r.if_mode;
   assign spi_3w_active = cur_r.if_mode && spi_three_wire;
   assign spi_cs_n = cur_r.if_mode ? spi_cs_n_in : 1'b1;
   assign wake_up = cur_r.wake;
   assign ext_sample_trigger = cur_r.trig;
   assign detect_en = cur_r.boot_mode && (cur_r.st == SPMC_ST_ARMED);
   assign hibernate = hib_now;
   assign motion_threshold = cur_r.thr;
   assign irq_a_in = !cur_r.boot_mode && cur_r.cfg_a == SPMC_IN && motion_line_in;
   assign irq_b_in = !cur_r.boot_mode && cur_r.cfg_b == SPMC_IN && pin6_in;

   // Serial data pins
   always_comb begin
      sdata_out = sdata_core_out;
      sdata_oe_n = sdata_core_oe_n;
      miso_out = miso_core_out;
      miso_oe_n = miso_core_oe_n;
      if (hib_now) begin
         sdata_oe_n = 1'b1;
         miso_oe_n = 1'b1;
      end else if (!cur_r.if_mode || spi_three_wire) begin
         miso_oe_n = 1'b1;
      end
   end

   spmc_irq_pad u_pad_a (
      .cfg(cur_r.cfg_a),
      .hiz(hib_now),
      .level(irq_a_level),
      .pin_out(irq_a_pin_out),
      .pin_oe_n(irq_a_pin_oe_n)
   );

   // Pin 8: interrupt a or motion line
   always_comb begin
      if (cur_r.boot_mode) begin
         motion_line_out = 1'b0;
         motion_line_oe_n = !(cur_r.st == SPMC_ST_PULSE);
      end else begin
         motion_line_out = irq_a_pin_out;
         motion_line_oe_n = irq_a_pin_oe_n;
      end
   end

   // Pin 6: boot-complete, interrupt b or trigger input
   logic irq_b_pin_out;
   logic irq_b_pin_oe_n;
   spmc_irq_pad u_pad_b (
      .cfg(ext_sample_trigger_sel ? SPMC_IN : cur_r.cfg_b),
      .hiz(hib_now),
      .level(irq_b_level),
      .pin_out(irq_b_pin_out),
      .pin_oe_n(irq_b_pin_oe_n)
   );
   always_comb begin
      if (cur_r.boot_mode) begin
         pin6_out = 1'b0;
         pin6_oe_n = hib_now || !cur_r.strap_done || (cur_r.st != SPMC_ST_BOOT);
      end else begin
         pin6_out = irq_b_pin_out;
         pin6_oe_n = irq_b_pin_oe_n;
      end
   end
endmodule
`default_nettype wire

// >>> spmc_checker.sv
// Checker for the pin steering block, bound to spmc_top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module spmc_checker #(
   parameter int unsigned PULSE_CYC = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Watched pins and status
   input wire logic boot_done,
   input wire logic motion_event,
   input wire logic motion_line_in,
   input wire logic motion_line_oe_n,
   input wire logic pin6_out,
   input wire logic pin6_oe_n,
   input wire logic sdata_oe_n,
   input wire logic miso_oe_n,
   input wire logic motion_mode,
   input wire logic spi_sel,
   input wire logic spi_3w_active,
   input wire logic wake_up,
   input wire logic ext_sample_trigger,
   input wire logic detect_en,
   input wire logic hibernate
);
   logic [23:0] lo_cnt_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Length of the current motion pulse
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lo_cnt_r <= 24'h000000;
      end else if (motion_mode && !motion_line_oe_n) begin
         lo_cnt_r <= lo_cnt_r + 24'h000001;
      end else begin
         lo_cnt_r <= 24'h000000;
      end
   end
   AST_PULSE_START: assert property (motion_mode && detect_en && motion_event && motion_line_in
      && motion_line_oe_n |=> !motion_line_oe_n) else $error("motion pulse missing");
   AST_PULSE_LEN: assert property (motion_mode && $past(motion_mode) && $rose(motion_line_oe_n)
      |-> lo_cnt_r == PULSE_CYC) else $error("motion pulse width wrong");
   AST_HIB_HIZ: assert property (hibernate |-> pin6_oe_n && sdata_oe_n && miso_oe_n
      && motion_line_oe_n) else $error("pin driven in hibernate");
   AST_STRAP_HOLD: assert property (!$past(rst) && !$past(rst, 2)
      |-> $stable(motion_mode) && $stable(spi_sel)) else $error("strap value changed");
   AST_WAKE: assert property (wake_up |-> !motion_mode) else $error("wake in motion mode");
   AST_TRIG: assert property (ext_sample_trigger |-> !motion_mode) else $error("bad trigger");
   AST_3W: assert property (spi_3w_active |-> spi_sel) else $error("three wire without spi");
   AST_OD: assert property (motion_mode && !pin6_oe_n |-> !pin6_out) else $error("pin6 high");
   AST_BOOT_REL: assert property (motion_mode && boot_done |=> pin6_oe_n)
      else $error("boot pin not released");
   cover property (motion_mode && $fell(motion_line_oe_n));
   cover property (motion_mode && hibernate);
   cover property (wake_up);
endmodule
bind spmc_top spmc_checker #(.PULSE_CYC(PULSE_CYC)) u_spmc_checker (.*);
`default_nettype wire

// >>> spmc_host_model.sv
// Host side of the shared motion line, with its pull-up.
// Assumes the boot pin joins the line only in motion-detection mode.
`timescale 1ns/100ps
`default_nettype none
module spmc_host_model (
   // Host drive
   input wire logic host_lo,
   // Device pins
   input wire logic dev_out,
   input wire logic dev_oe_n,
   input wire logic boot_out,
   input wire logic boot_oe_n,
   // Resolved line
   output logic line
);
   // Pull-up wins unless a party sinks the line
   assign line = !(host_lo || (!dev_oe_n && !dev_out) || (!boot_oe_n && !boot_out));
endmodule
`default_nettype wire

// >>> spmc_top_tb.sv
// Testbench for spmc_top in both boot modes.
// Assumes short count parameters and the host model on the motion line.
`timescale 1ns/100ps
`default_nettype none
module spmc_top_tb;
   import spmc_pkg::*;
   localparam int unsigned HIB_ENTRY_CYC = 4;
   localparam int unsigned PULSE_CYC = 3;
   logic clk_sys = 1'b0, rst = 1'b1, boot_mode_strap = 1'b0, host_if_strap = 1'b1;
   spmc_irq_cfg_type irq_a_cfg = SPMC_PP, irq_b_cfg = SPMC_PP;
   logic spi_three_wire = 1'b0, irq_cfg_load = 1'b0, ext_sample_trigger_sel = 1'b0, hib_req = 1'b0;
   logic irq_a_level = 1'b0, irq_b_level = 1'b0, boot_done = 1'b0, motion_event = 1'b0;
   logic spi_cs_n_in = 1'b1, sdata_in = 1'b1, sdata_core_out = 1'b1, sdata_core_oe_n = 1'b0;
   logic miso_core_out = 1'b1, miso_core_oe_n = 1'b0, pin6_in = 1'b0, host_lo = 1'b0;
   logic motion_line_in, sdata_out, sdata_oe_n, miso_out, miso_oe_n, pin6_out, pin6_oe_n;
   logic motion_line_out, motion_line_oe_n, motion_mode, spi_sel, spi_3w_active, spi_cs_n;
   logic wake_up, ext_sample_trigger, detect_en, hibernate, irq_a_in, irq_b_in;
   logic [1:0] motion_threshold;
   int err_total = 0, checks = 0, i, n;
   always #2 clk_sys = ~clk_sys;
   spmc_top #(.HIB_ENTRY_CYC(HIB_ENTRY_CYC), .PULSE_CYC(PULSE_CYC)) u_spmc_top (.*);
   spmc_host_model u_spmc_host_model (.host_lo(host_lo), .dev_out(motion_line_out),
      .dev_oe_n(motion_line_oe_n), .boot_out(pin6_out),
      .boot_oe_n(pin6_oe_n || !boot_mode_strap), .line(motion_line_in));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic bound(input int k);
      if (k >= 40) begin
         $display("wrong value wait expected 1 seen 0");
         err_total++;
         report_and_stop();
      end
   endtask
   task automatic do_reset(input logic bm, input logic ifs);
      rst = 1'b1;
      boot_mode_strap = bm;
      host_if_strap = ifs;
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic t_default_mode();
      do_reset(1'b0, 1'b1);
      chk("motion_mode", 8'h00, motion_mode);
      chk("spi_sel", 8'h01, spi_sel);
      chk("serial out", 8'h03, {sdata_out, miso_out});
      host_if_strap = 1'b0;
      spi_three_wire = 1'b1;
      for (i = 0; i < 40 && !spi_3w_active; i++) @(negedge clk_sys);
      bound(i);
      chk("miso off", 8'h01, miso_oe_n);
      repeat (2) @(negedge clk_sys);
      chk("spi_sel held", 8'h01, spi_sel);
      chk("irq a driven", 8'h00, motion_line_oe_n);
      irq_a_cfg = SPMC_IN;
      irq_b_cfg = SPMC_IN;
      irq_cfg_load = 1'b1;
      @(negedge clk_sys);
      irq_cfg_load = 1'b0;
      host_lo = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("irq a input", 8'h01, {irq_a_in, motion_line_oe_n});
      host_lo = 1'b0;
      @(negedge clk_sys);
      chk("irq a high", 8'h01, irq_a_in);
      ext_sample_trigger_sel = 1'b1;
      pin6_in = 1'b1;
      for (i = 0; i < 40 && !ext_sample_trigger; i++) @(negedge clk_sys);
      bound(i);
      chk("pin6 input", 8'h01, pin6_oe_n);
      chk("irq b input", 8'h01, irq_b_in);
      hib_req = 1'b1;
      for (i = 0; i < 40 && !hibernate; i++) @(negedge clk_sys);
      bound(i);
      chk("hiz pins", 8'h07, {sdata_oe_n, miso_oe_n, motion_line_oe_n});
      spi_cs_n_in = 1'b0;
      for (i = 0; i < 40 && !wake_up; i++) @(negedge clk_sys);
      bound(i);
      chk("spi_cs_n", 8'h00, spi_cs_n);
      spi_cs_n_in = 1'b1;
      hib_req = 1'b0;
      for (i = 0; i < 40 && hibernate; i++) @(negedge clk_sys);
      bound(i);
      @(negedge clk_sys);
      chk("irq a push-pull", 8'h00, motion_line_oe_n);
      $display("default mode test done");
   endtask
   task automatic t_motion_mode();
      do_reset(1'b1, 1'b0);
      chk("motion_mode", 8'h01, motion_mode);
      chk("spi_sel", 8'h00, spi_sel);
      chk("spi_cs_n i2c", 8'h01, spi_cs_n);
      chk("boot pin low", 8'h00, {pin6_oe_n, pin6_out});
      motion_event = 1'b1;
      @(negedge clk_sys);
      motion_event = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("early event", 8'h01, motion_line_oe_n);
      boot_done = 1'b1;
      for (i = 0; i < 40 && !detect_en; i++) @(negedge clk_sys);
      bound(i);
      chk("boot pin free", 8'h01, pin6_oe_n);
      motion_event = 1'b1;
      @(negedge clk_sys);
      motion_event = 1'b0;
      n = 0;
      for (i = 0; i < 20; i++) begin
         n += !motion_line_oe_n;
         @(negedge clk_sys);
      end
      chk("pulse cycles", 8'(PULSE_CYC), 8'(n));
      host_lo = 1'b1;
      repeat (2) @(negedge clk_sys);
      host_lo = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("threshold", 8'h01, motion_threshold);
      host_lo = 1'b1;
      for (i = 0; i < 40 && !hibernate; i++) @(negedge clk_sys);
      bound(i);
      chk("hib entry cycles", 8'(HIB_ENTRY_CYC), 8'(i));
      chk("line input", 8'h01, motion_line_oe_n);
      host_lo = 1'b0;
      for (i = 0; i < 40 && hibernate; i++) @(negedge clk_sys);
      bound(i);
      $display("motion mode test done");
   endtask
   initial begin
      t_default_mode();
      t_motion_mode();
      report_and_stop();
   end
endmodule
`default_nettype wire
